// ==== pkg/uart_rx_pkg.sv ====
// constants and types shared by the asynchronous receive front end
package uart_rx_pkg;

  // samples per bit and centre voting window
  localparam logic [4:0] SPB_NORMAL        = 5'h10;
  localparam logic [4:0] SPB_DOUBLE        = 5'h08;
  localparam logic [4:0] VOTE_FIRST_NORMAL = 5'h08;
  localparam logic [4:0] VOTE_FIRST_DOUBLE = 5'h04;
  localparam logic [4:0] VOTE_SPAN         = 5'h02;
  // double speed releases the stop bit one sample after its last vote
  localparam logic [4:0] STOP_EXIT_DOUBLE  = 5'h07;
  localparam logic [4:0] FIRST_SAMPLE      = 5'h01;

  // frame geometry: data plus parity bits, 5 to 10
  localparam int         MAX_BITS   = 10;
  localparam logic [3:0] MAX_BITS_W = 4'ha;
  localparam int         WORD_W     = MAX_BITS + 1;
  localparam int         FIFO_DEPTH = 16;

  typedef enum logic [3:0] {
    PH_IDLE  = 4'h1,
    PH_START = 4'h2,
    PH_DATA  = 4'h4,
    PH_STOP  = 4'h8
  } phase_t;

  typedef struct packed {
    phase_t              phase;
    logic [4:0]          sampleCnt;
    logic [3:0]          bitIdx;
    logic [1:0]          votes;
    logic [MAX_BITS-1:0] shift;
    logic                prevRx;
    logic                dbl;
    logic [3:0]          len;
    logic                pendValid;
    logic [WORD_W-1:0]   pendWord;
    logic                overrun;
    logic                outValid;
    logic [MAX_BITS-1:0] outData;
    logic                outFerr;
  } rx_state_t;

  localparam rx_state_t RX_RESET = '{phase: PH_IDLE, default: '0};

endpackage

// ==== logic/rx_fifo.sv ====
// synchronous fifo with valid/ready on both sides
`timescale 1ns/100ps
`default_nettype none
module rx_fifo #(
  parameter int WIDTH = 11,
  parameter int DEPTH = 16
) (
  // clock and reset
  input  wire logic             clk_sys,
  input  wire logic             reset_n,
  // fill side
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  // drain side
  output logic                  outValid,
  input  wire logic             outReady,
  output logic [WIDTH-1:0]      outData
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0]               wrPtr;
    logic [PW-1:0]               rdPtr;
    logic [CW-1:0]               count;
  } fifo_state_t;

  fifo_state_t q;
  fifo_state_t d;
  logic        doWrite;
  logic        doRead;

  assign inReady  = (q.count != FULL_CNT);
  assign outValid = (q.count != '0);
  assign outData  = q.mem[q.rdPtr];
  assign doWrite  = inValid && inReady;
  assign doRead   = outValid && outReady;

  always_comb begin
    d = q;
    if (doWrite) begin
      d.mem[q.wrPtr] = inData;
      d.wrPtr        = (q.wrPtr == PW'(DEPTH - 1)) ? '0 : q.wrPtr + 1'b1;
    end
    if (doRead) begin
      d.rdPtr = (q.rdPtr == PW'(DEPTH - 1)) ? '0 : q.rdPtr + 1'b1;
    end
    case ({doWrite, doRead})
      2'b10:   d.count = q.count + 1'b1;
      2'b01:   d.count = q.count - 1'b1;
      default: d.count = q.count;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

endmodule // rx_fifo
`default_nettype wire

// ==== logic/uart_async_rx_recovery.sv ====
// asynchronous receive clock and data recovery with frame buffer
// Operation
// (R1) the line is sampled at 16 samples per bit normally and 8 per bit in double speed.
// (R2) a high to low fall of the idle line starts detection, that first low sample being number one.
// (R3) start validity is voted on samples 8, 9, 10 normally and 4, 5, 6 in double speed.
// (R4) two or more high votes reject the start as noise and the hunt for a falling edge resumes.
// (R5) bit timing restarts at every valid start bit and data recovery begins only afterwards.
// (R6) recovery steps one state per sample, each sample numbered by its state within the bit.
// (R7) each bit value is the majority of its three centre samples.
// (R8) bits are recovered up to the first stop bit and later stop bits are ignored.
// (R9) the first stop bit is voted the same way and a zero sets the frame error flag.
// (R10) normally a new edge is accepted right after the last stop vote, later in double speed.
// (R11) incoming rates between the slow and fast ratio limits set by the first vote sample are tolerated.
// (R12) transmitter and receiver should each keep their rate error within half the total tolerance.
// (R13) state advances only on sample ticks from the baud generator and reset returns to the hunt.
`timescale 1ns/100ps
`default_nettype none
module uart_async_rx_recovery (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  // baud generator and configuration
  input  wire logic        sampleTick,
  input  wire logic        doubleSpeedSelect,
  input  wire logic [3:0]  frameBits,
  // serial line
  input  wire logic        rxLine,
  // received words
  output logic             rxValid,
  input  wire logic        rxReady,
  output logic [9:0]       rxData,
  output logic             frameErrorFlag,
  output logic             overrunPulse
);

  uart_rx_pkg::rx_state_t q;
  uart_rx_pkg::rx_state_t d;

  logic [4:0]                      spb;
  logic [4:0]                      voteFirst;
  logic [4:0]                      voteLast;
  logic                            centreMaj;
  logic                            fifoInReady;
  logic                            fifoOutValid;
  logic                            fifoOutReady;
  logic [uart_rx_pkg::WORD_W-1:0]  fifoOutData;
  logic [9:0]                      aligned;
  logic                            blocked;

  // mode is latched per frame so a mid-frame change cannot skew timing
  // (R1) samples per bit
  assign spb       = q.dbl ? uart_rx_pkg::SPB_DOUBLE : uart_rx_pkg::SPB_NORMAL;
  // (R3) centre window
  assign voteFirst = q.dbl ? uart_rx_pkg::VOTE_FIRST_DOUBLE : uart_rx_pkg::VOTE_FIRST_NORMAL;
  // (R11) vote window sets range
  assign voteLast  = voteFirst + uart_rx_pkg::VOTE_SPAN;
  // (R7) two of three
  assign centreMaj = (q.votes[0] & q.votes[1]) | (q.votes[0] & rxLine) | (q.votes[1] & rxLine);
  // lsb arrives first, so short frames sit high in the shifter
  assign aligned   = q.shift >> (uart_rx_pkg::MAX_BITS_W - q.len);
  assign blocked   = q.pendValid && !fifoInReady;
  assign fifoOutReady = !q.outValid || rxReady;

  rx_fifo #(
    .WIDTH (uart_rx_pkg::WORD_W),
    .DEPTH (uart_rx_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk_sys  (clk_sys),
    .reset_n  (reset_n),
    .inValid  (q.pendValid),
    .inReady  (fifoInReady),
    .inData   (q.pendWord),
    .outValid (fifoOutValid),
    .outReady (fifoOutReady),
    .outData  (fifoOutData)
  );

  always_comb begin
    d = q;
    d.overrun = 1'b0;
    if (q.pendValid && fifoInReady) begin
      d.pendValid = 1'b0;
    end
    if (fifoOutValid && fifoOutReady) begin
      d.outValid = 1'b1;
      d.outData  = fifoOutData[9:0];
      d.outFerr  = fifoOutData[10];
    end else if (rxReady) begin
      d.outValid = 1'b0;
    end
    // (R13) tick gated
    if (sampleTick) begin
      d.prevRx = rxLine;
      case (q.phase)
        uart_rx_pkg::PH_IDLE: begin
          // (R2) falling edge
          if (q.prevRx && !rxLine) begin
            d.phase     = uart_rx_pkg::PH_START;
            // counter names the sample the next tick takes
            d.sampleCnt = uart_rx_pkg::FIRST_SAMPLE + 5'h01;
            d.dbl       = doubleSpeedSelect;
            d.len       = frameBits;
          end
        end
        uart_rx_pkg::PH_START: begin
          // (R6) one state per sample
          d.sampleCnt = q.sampleCnt + 5'h01;
          if (q.sampleCnt == voteFirst) begin
            d.votes[0] = rxLine;
          end
          if (q.sampleCnt == voteFirst + 5'h01) begin
            d.votes[1] = rxLine;
          end
          if (q.sampleCnt == voteLast && centreMaj) begin
            // (R4) noise rejected
            d.phase = uart_rx_pkg::PH_IDLE;
          end else if (q.sampleCnt == spb) begin
            // (R5) resync to start
            d.phase     = uart_rx_pkg::PH_DATA;
            d.sampleCnt = uart_rx_pkg::FIRST_SAMPLE;
            d.bitIdx    = 4'h0;
          end
        end
        uart_rx_pkg::PH_DATA: begin
          d.sampleCnt = q.sampleCnt + 5'h01;
          if (q.sampleCnt == voteFirst) begin
            d.votes[0] = rxLine;
          end
          if (q.sampleCnt == voteFirst + 5'h01) begin
            d.votes[1] = rxLine;
          end
          // (R7) bit decided
          if (q.sampleCnt == voteLast) begin
            d.shift = {centreMaj, q.shift[9:1]};
          end
          if (q.sampleCnt == spb) begin
            d.sampleCnt = uart_rx_pkg::FIRST_SAMPLE;
            // (R8) stop after data
            if (q.bitIdx == q.len - 4'h1) begin
              d.phase = uart_rx_pkg::PH_STOP;
            end else begin
              d.bitIdx = q.bitIdx + 4'h1;
            end
          end
        end
        uart_rx_pkg::PH_STOP: begin
          d.sampleCnt = q.sampleCnt + 5'h01;
          if (q.sampleCnt == voteFirst) begin
            d.votes[0] = rxLine;
          end
          if (q.sampleCnt == voteFirst + 5'h01) begin
            d.votes[1] = rxLine;
          end
          if (q.sampleCnt == voteLast) begin
            // (R9) stop vote sets frame error
            if (blocked) begin
              d.overrun = 1'b1;
            end else begin
              d.pendValid = 1'b1;
              d.pendWord  = {!centreMaj, aligned};
            end
            // (R10) normal: hunt right away
            if (!q.dbl) begin
              d.phase = uart_rx_pkg::PH_IDLE;
            end
          end
          // (R10) double speed exit later
          if (q.dbl && q.sampleCnt == uart_rx_pkg::STOP_EXIT_DOUBLE) begin
            d.phase = uart_rx_pkg::PH_IDLE;
          end
        end
        default: d.phase = uart_rx_pkg::PH_IDLE;
      endcase
    end
  end

  // (R13) reset to hunt
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      q <= uart_rx_pkg::RX_RESET;
    end else begin
      q <= d;
    end
  end

  assign rxValid        = q.outValid;
  assign rxData         = q.outData;
  assign frameErrorFlag = q.outFerr;
  assign overrunPulse   = q.overrun;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  property p_tick_only;
    !sampleTick |=> q.phase == $past(q.phase) && q.sampleCnt == $past(q.sampleCnt);
  endproperty
  a_tick_only: assert property (p_tick_only) else $error("recovery moved without a tick"); // (R13)

  property p_start_enter;
    q.phase == uart_rx_pkg::PH_IDLE && sampleTick && q.prevRx && !rxLine
      |=> q.phase == uart_rx_pkg::PH_START && q.sampleCnt == 5'h02;
  endproperty
  a_start_enter: assert property (p_start_enter) else $error("falling edge not taken as sample one"); // (R2)

  property p_cnt_bound;
    q.phase != uart_rx_pkg::PH_IDLE |-> q.sampleCnt >= 5'h01 && q.sampleCnt <= (q.dbl ? 5'h08 : 5'h10);
  endproperty
  a_cnt_bound: assert property (p_cnt_bound) else $error("sample number outside the bit"); // (R1)

  property p_reject;
    q.phase == uart_rx_pkg::PH_START && sampleTick && q.sampleCnt == (q.dbl ? 5'h06 : 5'h0a) && centreMaj
      |=> q.phase == uart_rx_pkg::PH_IDLE;
  endproperty
  a_reject: assert property (p_reject) else $error("noisy start not rejected"); // (R4)

  property p_accept;
    q.phase == uart_rx_pkg::PH_START && sampleTick && q.sampleCnt == (q.dbl ? 5'h06 : 5'h0a) && !centreMaj
      |=> q.phase == uart_rx_pkg::PH_START && q.votes == $past(q.votes);
  endproperty
  a_accept: assert property (p_accept) else $error("valid start dropped"); // (R3)

  property p_resync;
    q.phase == uart_rx_pkg::PH_START && sampleTick && q.sampleCnt == spb
      |=> q.phase == uart_rx_pkg::PH_DATA && q.sampleCnt == 5'h01 && q.bitIdx == 4'h0;
  endproperty
  a_resync: assert property (p_resync) else $error("data not aligned to start bit"); // (R5)

  property p_wrap;
    q.phase == uart_rx_pkg::PH_DATA && sampleTick && q.sampleCnt == spb && q.bitIdx != q.len - 4'h1
      |=> q.phase == uart_rx_pkg::PH_DATA && q.sampleCnt == 5'h01 && q.bitIdx == $past(q.bitIdx) + 4'h1;
  endproperty
  a_wrap: assert property (p_wrap) else $error("bit state did not wrap"); // (R6)

  property p_bit_vote;
    q.phase == uart_rx_pkg::PH_DATA && sampleTick && q.sampleCnt == voteLast
      |=> q.shift[9] == $past(centreMaj);
  endproperty
  a_bit_vote: assert property (p_bit_vote) else $error("bit not the centre majority"); // (R7)

  property p_to_stop;
    q.phase == uart_rx_pkg::PH_DATA && sampleTick && q.sampleCnt == spb && q.bitIdx == q.len - 4'h1
      |=> q.phase == uart_rx_pkg::PH_STOP;
  endproperty
  a_to_stop: assert property (p_to_stop) else $error("stop bit not reached after data"); // (R8)

  property p_stop_err;
    q.phase == uart_rx_pkg::PH_STOP && sampleTick && q.sampleCnt == voteLast && !blocked
      |=> q.pendValid && q.pendWord[10] == !$past(centreMaj);
  endproperty
  a_stop_err: assert property (p_stop_err) else $error("frame error does not match stop vote"); // (R9)

  property p_stop_exit;
    q.phase == uart_rx_pkg::PH_STOP && sampleTick && q.sampleCnt == voteLast && !q.dbl
      |=> q.phase == uart_rx_pkg::PH_IDLE;
  endproperty
  a_stop_exit: assert property (p_stop_exit) else $error("hunt not resumed after stop vote"); // (R10)

  c_frame_ok:  cover property (q.phase == uart_rx_pkg::PH_STOP ##1 q.pendValid && !q.pendWord[10]);
  c_frame_err: cover property (q.phase == uart_rx_pkg::PH_STOP ##1 q.pendValid && q.pendWord[10]);
  c_noise:     cover property (q.phase == uart_rx_pkg::PH_START ##1 q.phase == uart_rx_pkg::PH_IDLE);
  c_overrun:   cover property (overrunPulse);

endmodule // uart_async_rx_recovery
`default_nettype wire

// ==== test/uart_tx_model.sv ====
// remote asynchronous transmitter model driving the receive line
`timescale 1ns/100ps
`default_nettype none
module uart_tx_model (
  // clock
  input  wire logic clk_sys,
  // serial line
  output logic      rxLine
);
  // idle line rests high, like a pulled-up wire
  initial rxLine = 1'b1;

  task automatic hold_bit(input logic v, input int clks);
    rxLine = v;
    repeat (clks) @(negedge clk_sys);
  endtask

  task automatic send_frame(input logic [9:0] d, input int nb, input int bitClk, input logic stopVal,
                            input int stopClk);
    hold_bit(1'b0, bitClk);
    for (int i = 0; i < nb; i++) begin
      hold_bit(d[i], bitClk);
    end
    hold_bit(stopVal, stopClk);
    // a low stop needs idle time, or the next start has no fall
    if (!stopVal) begin
      hold_bit(1'b1, stopClk);
    end
  endtask

  task automatic spike(input int clks);
    hold_bit(1'b0, clks);
    rxLine = 1'b1;
  endtask
endmodule // uart_tx_model
`default_nettype wire

// ==== test/uart_async_rx_recovery_bench.sv ====
// self-checking bench for the asynchronous receive front end
`timescale 1ns/100ps
`default_nettype none
module uart_async_rx_recovery_bench;
  logic        clk_sys;
  logic        reset_n;
  logic        sampleTick = 1'b0;
  logic        doubleSpeedSelect;
  logic [3:0]  frameBits;
  logic        rxLine;
  logic        rxValid;
  logic        rxReady;
  logic [9:0]  rxData;
  logic        frameErrorFlag;
  logic        overrunPulse;
  int          error_cnt = 0;
  int          cmp_count = 0;
  int          tickCnt = 0;
  int          ovfCnt = 0;
  logic [10:0] gotQ[$];

  uart_async_rx_recovery u_dut (.clk_sys(clk_sys), .reset_n(reset_n), .sampleTick(sampleTick),
    .doubleSpeedSelect(doubleSpeedSelect), .frameBits(frameBits), .rxLine(rxLine), .rxValid(rxValid),
    .rxReady(rxReady), .rxData(rxData), .frameErrorFlag(frameErrorFlag), .overrunPulse(overrunPulse));
  uart_tx_model u_tx (.clk_sys(clk_sys), .rxLine(rxLine));

  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  // one tick every four clocks: 64 clocks per normal bit
  always @(negedge clk_sys) begin
    tickCnt <= (tickCnt == 3) ? 0 : tickCnt + 1;
    sampleTick <= (tickCnt == 3);
  end

  // collect handed-over words and overrun pulses
  always @(posedge clk_sys) begin
    if (rxValid === 1'b1 && rxReady === 1'b1) begin
      gotQ.push_back({frameErrorFlag, rxData});
    end
    if (overrunPulse === 1'b1) begin
      ovfCnt++;
    end
  end

  task automatic give_verdict;
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic check(input logic [10:0] got, input logic [10:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // bounded wait, a missing word compares as the inverse
  task automatic expect_word(input logic [10:0] exp);
    logic [10:0] w;
    w = ~exp;
    for (int i = 0; i < 3000 && gotQ.size() == 0; i++) @(negedge clk_sys);
    if (gotQ.size() != 0) begin
      w = gotQ.pop_front();
    end
    check(w, exp);
  endtask

  task automatic send_one(input logic dbl, input int nb, input logic [9:0] d, input int bitClk, input logic stopVal);
    logic [9:0] mask;
    mask = 10'((11'h1 << nb) - 11'h1);
    doubleSpeedSelect = dbl;
    frameBits = 4'(nb);
    u_tx.send_frame(d, nb, bitClk, stopVal, bitClk);
    expect_word({~stopVal, d & mask});
  endtask

  // reset mid-frame drops it; an all-ones frame leaves no falls behind
  task automatic t_reset;
    fork
      u_tx.send_frame(10'h3ff, 8, 64, 1'b1, 64);
    join_none
    repeat (200) @(negedge clk_sys);
    reset_n = 1'b0;
    repeat (2) @(negedge clk_sys);
    reset_n = 1'b1;
    check({rxData, rxValid}, 11'h000);
    repeat (900) @(negedge clk_sys);
    check(11'(gotQ.size()), 11'h000);
  endtask

  task automatic t_modes;
    for (int m = 0; m < 2; m++) begin
      for (int nb = 5; nb <= 10; nb++) begin
        send_one(m[0], nb, 10'h2d3 ^ 10'(nb * 37), m ? 32 : 64, 1'b1);
      end
    end
  endtask

  task automatic t_noise;
    doubleSpeedSelect = 1'b0;
    u_tx.spike(32);
    repeat (100) @(negedge clk_sys);
    send_one(1'b0, 8, 10'h0a6, 64, 1'b1);
    doubleSpeedSelect = 1'b1;
    u_tx.spike(16);
    repeat (100) @(negedge clk_sys);
    send_one(1'b1, 8, 10'h059, 32, 1'b1);
  endtask

  // shortest stop each mode allows, next start right behind it
  task automatic t_b2b;
    for (int m = 0; m < 2; m++) begin
      doubleSpeedSelect = m[0];
      frameBits = 4'h8;
      u_tx.send_frame(10'h0c3, 8, m ? 32 : 64, 1'b1, m ? 28 : 40);
      u_tx.send_frame(10'h03c, 8, m ? 32 : 64, 1'b1, m ? 28 : 40);
      expect_word(11'h0c3);
      expect_word(11'h03c);
    end
  endtask

  // sink stalls: 18 words fit, the 19th is dropped
  task automatic t_fifo;
    rxReady = 1'b0;
    ovfCnt = 0;
    for (int i = 0; i < 19; i++) begin
      send_one_nowait(i);
    end
    repeat (50) @(negedge clk_sys);
    check(11'(ovfCnt), 11'h001);
    rxReady = 1'b1;
    for (int i = 0; i < 18; i++) begin
      expect_word(11'(i));
    end
    repeat (50) @(negedge clk_sys);
    check(11'(gotQ.size()), 11'h000);
  endtask

  task automatic send_one_nowait(input int i);
    doubleSpeedSelect = 1'b1;
    frameBits = 4'h5;
    u_tx.send_frame(10'(i), 5, 32, 1'b1, 32);
  endtask

  initial begin
    reset_n = 1'b0;
    doubleSpeedSelect = 1'b0;
    frameBits = 4'h8;
    rxReady = 1'b1;
    repeat (16) @(negedge clk_sys);
    reset_n = 1'b1;
    repeat (8) @(negedge clk_sys);
    t_reset();
    t_modes();
    send_one(1'b0, 7, 10'h055, 64, 1'b0);
    send_one(1'b0, 8, 10'h0b5, 67, 1'b1);
    send_one(1'b0, 8, 10'h14a, 62, 1'b1);
    t_noise();
    t_b2b();
    t_fifo();
    give_verdict();
  end

  initial begin
    repeat (60000) @(posedge clk_sys);
    error_cnt++;
    give_verdict();
  end
endmodule // uart_async_rx_recovery_bench
`default_nettype wire
